// File: core/boot_strap_reset_decoder.sv
// reset gating and boot strap capture, top level
`timescale 1ns/1ps
module boot_strap_reset_decoder
	import boot_strap_pkg::*;
#(
	parameter logic [27:0] BOOT_TIMEOUT = BOOT_CYCLES
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic fiveRisingOk,
	input wire logic fiveFallingLow,
	input wire logic threeRisingOk,
	input wire logic coreRisingOk,
	input wire logic inputUvloOk,
	input wire logic enableOperOk,
	input wire logic reducedVariant,
	input wire logic [7:0] adcCode,
	input wire logic adcValid,
	output logic logicReset,
	output logic coreReset,
	output logic adcRequest,
	output logic bootDone,
	output logic bootTimeout,
	output logic [3:0] strapIndex,
	output logic [6:0] addrA,
	output logic [6:0] addrB,
	output logic levelSel1v8,
	output logic [1:0] bootMode,
	output logic fwUpdateEndpoint
);
	typedef enum logic [1:0] {
		ST_RESET,
		ST_SAMPLE,
		ST_RUN
	} boot_state_t;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic fiveRise, fiveFall, threeRise, coreRise, vinOk, enOk;
	logic [5:0] rawPins;
	logic [5:0] syncPins;

	assign rawPins = {fiveRisingOk, fiveFallingLow, threeRisingOk,
		coreRisingOk, inputUvloOk, enableOperOk};

	for (genvar k = 0; k < 6; k++) begin : g_sync
		pin_sync u_sync (
			.clock(clock),
			.rst(rst),
			.pinIn(rawPins[k]),
			.level(syncPins[k])
		);
	end

	assign {fiveRise, fiveFall, threeRise, coreRise, vinOk, enOk} = syncPins;

	// ************************************************************
	// reset gating
	// ************************************************************
	logic hardReset;
	logic logicRun;
	logic allRails;

	// falling comparator is a hard reset
	assign hardReset = rst | fiveFall;
	// logic only runs with five volt rail up
	// enable and input undervoltage both clear
	// enable dip drops run and forces reboot
	assign logicRun = fiveRise & vinOk & enOk;
	assign allRails = logicRun & threeRise & coreRise;

	always_ff @(posedge clock) begin
		if (hardReset) begin
			logicReset <= 1'b1;
		end else begin
			logicReset <= ~logicRun;
		end
	end

	// ************************************************************
	// boot sequencer
	// ************************************************************
	boot_state_t state_reg;
	logic [27:0] timer_reg;
	logic bootEnd;

	assign bootEnd = timer_reg >= BOOT_TIMEOUT - 28'h1;

	always_ff @(posedge clock) begin
		if (hardReset || !logicRun) begin
			state_reg <= ST_RESET;
		end else begin
			unique case (state_reg)
				ST_RESET: begin
					if (allRails) begin
						state_reg <= ST_SAMPLE;
					end
				end
				ST_SAMPLE: begin
					if (adcValid || bootEnd) begin
						state_reg <= ST_RUN;
					end
				end
				ST_RUN: begin
					state_reg <= ST_RUN;
				end
				default: begin
					state_reg <= ST_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (hardReset || state_reg != ST_SAMPLE) begin
			timer_reg <= 28'h0;
		end else if (!bootEnd) begin
			timer_reg <= timer_reg + 28'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (hardReset || !logicRun) begin
			adcRequest <= 1'b0;
		end else begin
			adcRequest <= state_reg == ST_SAMPLE && !adcValid && !bootEnd;
		end
	end

	always_ff @(posedge clock) begin
		if (hardReset || !logicRun) begin
			bootDone <= 1'b0;
		end else begin
			bootDone <= state_reg == ST_RUN;
		end
	end

	always_ff @(posedge clock) begin
		if (hardReset || !logicRun) begin
			bootTimeout <= 1'b0;
		end else if (state_reg == ST_SAMPLE && bootEnd && !adcValid) begin
			bootTimeout <= 1'b1;
		end
	end

	// core released only with all rails
	always_ff @(posedge clock) begin
		if (hardReset || !logicRun) begin
			coreReset <= 1'b1;
		end else begin
			coreReset <= !(allRails && state_reg == ST_RUN);
		end
	end

	// ************************************************************
	// strap decode and capture
	// ************************************************************
	logic [3:0] decIndex;
	logic [6:0] decA, decB;
	i2c_level_t decLevel;
	boot_mode_t decMode;
	logic capture;

	strap_decode u_decode (
		.adcCode(adcCode),
		.reducedVariant(reducedVariant),
		.strapIndex(decIndex),
		.addrA(decA),
		.addrB(decB),
		.level(decLevel),
		.mode(decMode)
	);

	assign capture = state_reg == ST_SAMPLE && adcValid;

	always_ff @(posedge clock) begin
		if (hardReset || !logicRun) begin
			strapIndex <= INDEX_RESET;
			addrA <= ADDR_A_LOW;
			addrB <= ADDR_B_LOW;
			levelSel1v8 <= 1'b0;
			bootMode <= BOOT_EEPROM;
			fwUpdateEndpoint <= 1'b0;
		end else if (capture) begin
			strapIndex <= decIndex;
			addrA <= decA;
			addrB <= decB;
			levelSel1v8 <= decLevel == LVL_1V8;
			bootMode <= decMode;
			fwUpdateEndpoint <= decMode == BOOT_FW_UPDATE;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_fall_hard_reset: assert property (
		fiveFall |=> logicReset && coreReset)
		else $error("falling rail did not reset");

	a_rise_gates_run: assert property (
		!fiveRise |=> logicReset)
		else $error("logic ran without rail up");

	a_core_needs_rails: assert property (
		!(threeRise && coreRise && fiveRise) |=> coreReset)
		else $error("core released early");

	a_enable_gates: assert property (
		!(vinOk && enOk) |=> logicReset && !bootDone)
		else $error("started without enable");

	a_reboot_clears: assert property (
		!enOk |=> !bootDone && strapIndex == INDEX_RESET)
		else $error("enable dip did not clear boot");

	a_hold_settings: assert property (
		state_reg == ST_RUN && $past(state_reg) == ST_RUN && logicRun
		&& !fiveFall |=> $stable(strapIndex) && $stable(addrA)
		&& $stable(addrB) && $stable(levelSel1v8) && $stable(bootMode))
		else $error("settings changed after boot");

	a_request_off: assert property (
		state_reg != ST_SAMPLE |=> !adcRequest)
		else $error("sample requested outside boot");

	a_capture_index: assert property (
		capture && !fiveFall && !reducedVariant && adcCode <= BOUND0
		|=> strapIndex == 4'h0)
		else $error("index 0 not decoded");

	a_mid_index: assert property (
		capture && logicRun && !fiveFall && !reducedVariant
		&& adcCode > BOUND3 && adcCode <= BOUND4 |=> strapIndex == 4'h4)
		else $error("index 4 not decoded");

	a_fw_index: assert property (
		capture && logicRun && !fiveFall && adcCode > BOUND7
		|=> strapIndex == INDEX_FW && fwUpdateEndpoint
		&& bootMode == BOOT_FW_UPDATE)
		else $error("firmware update not selected");

	a_reduced_map: assert property (
		capture && !fiveFall && reducedVariant && adcCode <= REDUCED_BOUND
		|=> strapIndex == 4'h0 && bootMode == BOOT_EEPROM)
		else $error("reduced variant decode wrong");

	a_addr_pair: assert property (
		bootDone |-> (addrB == ADDR_B_HIGH) == (addrA == ADDR_A_HIGH))
		else $error("address pair mismatch");

	a_addr_index: assert property (
		bootDone |-> (addrA == ADDR_A_HIGH)
		== (strapIndex inside {4'h1, 4'h3, 4'h4, 4'h6}))
		else $error("address not chosen by index");

	a_level_map: assert property (
		bootDone |-> levelSel1v8
		== (strapIndex inside {4'h2, 4'h3, 4'h6, 4'h7}))
		else $error("logic level not chosen by index");

	a_mode_map: assert property (
		bootDone && strapIndex != INDEX_FW
		|-> bootMode == {1'b0, strapIndex[0]})
		else $error("boot mode not chosen by index");

	a_boot_bound: assert property (
		state_reg == ST_SAMPLE && bootEnd && logicRun && !fiveFall
		|=> state_reg == ST_RUN)
		else $error("boot did not finish in time");

	a_timeout_flag: assert property (
		state_reg == ST_SAMPLE && bootEnd && !adcValid && logicRun
		&& !fiveFall |=> bootTimeout)
		else $error("timeout not flagged");

	c_normal_boot: cover property (capture ##1 bootDone);
	c_fw_boot: cover property (fwUpdateEndpoint);
	c_timeout: cover property (bootTimeout);
	c_reboot: cover property (bootDone ##1 !enOk);
	c_reduced_boot: cover property (capture && reducedVariant);
endmodule

// File: core/boot_strap_pkg.sv
// constants and types for the boot strap reset decoder
package boot_strap_pkg;
	// ************************************************************
	// strap index bounds, inclusive upper adc codes
	// ************************************************************
	localparam logic [7:0] BOUND0 = 8'h0a;
	localparam logic [7:0] BOUND1 = 8'h18;
	localparam logic [7:0] BOUND2 = 8'h2a;
	localparam logic [7:0] BOUND3 = 8'h3f;
	localparam logic [7:0] BOUND4 = 8'h59;
	localparam logic [7:0] BOUND5 = 8'h77;
	localparam logic [7:0] BOUND6 = 8'h9c;
	localparam logic [7:0] BOUND7 = 8'hc9;
	localparam logic [7:0] BOUND8 = 8'hff;
	localparam logic [7:0] REDUCED_BOUND = 8'hc9;
	localparam logic [3:0] INDEX_FW = 4'h8;
	// ************************************************************
	// target addresses, 7 bit
	// ************************************************************
	localparam logic [6:0] ADDR_A_LOW = 7'h22;
	localparam logic [6:0] ADDR_B_LOW = 7'h26;
	localparam logic [6:0] ADDR_A_HIGH = 7'h23;
	localparam logic [6:0] ADDR_B_HIGH = 7'h27;
	// ************************************************************
	// reset values and timing
	// ************************************************************
	localparam logic [3:0] INDEX_RESET = 4'h0;
	localparam int CLOCK_MHZ = 50;
	localparam int BOOT_TIME_S = 4;
	localparam longint BOOT_CYCLES_L = longint'(BOOT_TIME_S)
		* longint'(CLOCK_MHZ) * 64'h0f4240;
	localparam logic [27:0] BOOT_CYCLES = BOOT_CYCLES_L[27:0];
	localparam logic [2:0] SYNC_RESET = 3'h0;

	typedef enum logic [1:0] {
		BOOT_EEPROM,
		BOOT_HOST,
		BOOT_FW_UPDATE
	} boot_mode_t;

	typedef enum logic [1:0] {
		LVL_3V3,
		LVL_1V8
	} i2c_level_t;
endpackage

// File: core/pin_sync.sv
// three flop synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
	import boot_strap_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic pinIn,
	output logic level
);
	logic [2:0] stage_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			stage_reg <= SYNC_RESET;
		end else begin
			stage_reg <= {stage_reg[1:0], pinIn};
		end
	end

	// change counts once second and third agree
	always_ff @(posedge clock) begin
		if (rst) begin
			level <= 1'b0;
		end else if (stage_reg[1] == stage_reg[2]) begin
			level <= stage_reg[2];
		end
	end
endmodule

// File: core/strap_decode.sv
// combinational strap code to settings decoder
`timescale 1ns/1ps
module strap_decode
	import boot_strap_pkg::*;
(
	input wire logic [7:0] adcCode,
	input wire logic reducedVariant,
	output logic [3:0] strapIndex,
	output logic [6:0] addrA,
	output logic [6:0] addrB,
	output i2c_level_t level,
	output boot_mode_t mode
);
	logic [7:0] bounds [9];
	logic [8:0] below;
	logic highAddr;

	assign bounds = '{BOUND0, BOUND1, BOUND2, BOUND3, BOUND4,
		BOUND5, BOUND6, BOUND7, BOUND8};

	for (genvar i = 0; i < 9; i++) begin : g_cmp
		assign below[i] = adcCode <= bounds[i];
	end

	always_comb begin
		strapIndex = INDEX_FW;
		for (int j = 8; j >= 0; j--) begin
			if (below[j]) begin
				strapIndex = 4'(j);
			end
		end
		if (reducedVariant) begin
			strapIndex = (adcCode <= REDUCED_BOUND) ? INDEX_RESET : INDEX_FW;
		end
	end

	always_comb begin
		highAddr = strapIndex inside {4'h1, 4'h3, 4'h4, 4'h6};
		addrA = highAddr ? ADDR_A_HIGH : ADDR_A_LOW;
		addrB = highAddr ? ADDR_B_HIGH : ADDR_B_LOW;
		level = (strapIndex inside {4'h2, 4'h3, 4'h6, 4'h7}) ? LVL_1V8
			: LVL_3V3;
		if (strapIndex == INDEX_FW) begin
			mode = BOOT_FW_UPDATE;
		end else if (strapIndex[0]) begin
			mode = BOOT_HOST;
		end else begin
			mode = BOOT_EEPROM;
		end
	end
endmodule

// File: sim/strap_adc_model.sv
// strap adc stand-in answering the decoder's sample request
`timescale 1ns/1ps
module strap_adc_model (
	input wire logic clock,
	input wire logic mute,
	input wire logic spurious,
	input wire logic [7:0] codeIn,
	input wire logic adcRequest,
	output logic [7:0] adcCode,
	output logic adcValid
);
	logic [2:0] waitCnt = 3'h0;
	logic hit;
	initial adcCode = 8'h5a;
	initial adcValid = 1'b0;
	assign hit = spurious || (adcRequest && !mute && waitCnt == 3'h3);
	always @(posedge clock) begin
		if (!adcRequest || mute) begin
			waitCnt <= 3'h0;
			adcValid <= spurious;
		end else if (waitCnt != 3'h3) begin
			waitCnt <= waitCnt + 3'h1;
		end else begin
			adcValid <= 1'b1;
		end
	end
	// idle data shows inverse of last value
	always @(posedge clock) begin
		adcCode <= hit ? codeIn : ~adcCode;
	end
endmodule

// File: sim/boot_strap_reset_decoder_test.sv
// self-checking bench for the boot strap reset decoder
`timescale 1ns/1ps
module boot_strap_reset_decoder_test;
	logic clock = 0, rst = 1, fiveFallingLow = 0, reducedVariant = 0;
	logic mute = 0, spurious = 0;
	logic [4:0] rails = 5'h0;
	logic [7:0] codeIn = 8'h00, adcCode;
	logic adcValid, logicReset, coreReset, adcRequest, bootDone;
	logic bootTimeout, levelSel1v8, fwUpdateEndpoint;
	logic [3:0] strapIndex;
	logic [6:0] addrA, addrB;
	logic [1:0] bootMode;
	int error_cnt = 0, checked = 0, cyc = 0;
	logic [7:0] bnd [9] = '{8'h0a, 8'h18, 8'h2a, 8'h3f, 8'h59, 8'h77,
		8'h9c, 8'hc9, 8'hff};
	boot_strap_reset_decoder #(.BOOT_TIMEOUT(28'd50))
		i_boot_strap_reset_decoder (.clock(clock), .rst(rst),
		.fiveRisingOk(rails[0]), .fiveFallingLow(fiveFallingLow),
		.threeRisingOk(rails[1]), .coreRisingOk(rails[2]),
		.inputUvloOk(rails[3]), .enableOperOk(rails[4]),
		.reducedVariant(reducedVariant), .adcCode(adcCode),
		.adcValid(adcValid), .logicReset(logicReset),
		.coreReset(coreReset), .adcRequest(adcRequest),
		.bootDone(bootDone), .bootTimeout(bootTimeout),
		.strapIndex(strapIndex), .addrA(addrA), .addrB(addrB),
		.levelSel1v8(levelSel1v8), .bootMode(bootMode),
		.fwUpdateEndpoint(fwUpdateEndpoint));
	strap_adc_model i_strap_adc_model (.clock(clock), .mute(mute),
		.spurious(spurious), .codeIn(codeIn), .adcRequest(adcRequest),
		.adcCode(adcCode), .adcValid(adcValid));
	initial forever #10 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end
	// ****************************************
	// helpers and scenarios
	// ****************************************
	task automatic test_done();
		if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic waitDone();
		for (int i = 0; i < 200 && bootDone !== 1'b1; i++) cycles(1);
	endtask
	task automatic power(input logic [4:0] r, input logic [7:0] c);
		@(posedge clock);
		rails <= 5'h0;
		cycles(8);
		@(posedge clock);
		codeIn <= c;
		rails <= r;
	endtask
	task automatic boot_check(input logic [7:0] c, input logic red);
		int idx;
		logic hi, lv;
		idx = 8;
		for (int i = 8; i >= 0; i--)
			if (c <= bnd[i]) idx = i;
		if (red) idx = (c <= 8'hc9) ? 0 : 8;
		hi = idx inside {1, 3, 4, 6};
		lv = idx inside {2, 3, 6, 7};
		@(posedge clock);
		reducedVariant <= red;
		power(5'h1f, c);
		waitDone();
		chk("bootDone", 8'h1, bootDone);
		chk("coreReset", 8'h0, coreReset);
		chk("strapIndex", 8'(idx), strapIndex);
		chk("addrA", hi ? 8'b0100011 : 8'b0100010, addrA);
		chk("addrB", hi ? 8'b0100111 : 8'b0100110, addrB);
		chk("levelSel1v8", 8'(lv), levelSel1v8);
		chk("bootMode", idx == 8 ? 8'h2 : 8'(idx % 2), bootMode);
		chk("fwUpdate", 8'(idx == 8), fwUpdateEndpoint);
		chk("logicReset", 8'h0, logicReset);
		chk("bootTimeout", 8'h0, bootTimeout);
		chk("adcRequest", 8'h0, adcRequest);
	endtask
	task automatic t_decode();
		for (int i = 0; i < 9; i++) begin
			boot_check(bnd[i], 1'b0);
			if (i < 8) boot_check(bnd[i] + 8'h1, 1'b0);
		end
		boot_check(8'h00, 1'b1);
		boot_check(8'hc9, 1'b1);
		boot_check(8'hca, 1'b1);
	endtask
	task automatic t_hold();
		boot_check(8'h30, 1'b0);
		@(posedge clock);
		codeIn <= 8'hff;
		spurious <= 1'b1;
		cycles(30);
		chk("heldIndex", 8'h3, strapIndex);
		chk("heldMode", 8'h1, bootMode);
		chk("heldFw", 8'h0, fwUpdateEndpoint);
		@(posedge clock);
		spurious <= 1'b0;
	endtask
	task automatic t_rails();
		for (int b = 0; b < 5; b++) begin
			power(5'h1f ^ (5'h1 << b), 8'h30);
			cycles(20);
			chk("coreReset", 8'h1, coreReset);
			chk("adcRequest", 8'h0, adcRequest);
			chk("logicReset", 8'(b == 0 || b >= 3), logicReset);
			@(posedge clock);
			rails <= 5'h1f;
			waitDone();
			chk("bootDone", 8'h1, bootDone);
			chk("strapIndex", 8'h3, strapIndex);
		end
	endtask
	task automatic t_fall();
		@(posedge clock);
		fiveFallingLow <= 1'b1;
		codeIn <= 8'h50;
		cycles(8);
		chk("logicReset", 8'h1, logicReset);
		chk("bootDone", 8'h0, bootDone);
		chk("strapIndex", 8'h0, strapIndex);
		@(posedge clock);
		fiveFallingLow <= 1'b0;
		waitDone();
		chk("strapIndex", 8'h4, strapIndex);
	endtask
	task automatic t_dip();
		@(posedge clock);
		rails[4] <= 1'b0;
		codeIn <= 8'h70;
		cycles(6);
		chk("bootDone", 8'h0, bootDone);
		chk("strapIndex", 8'h0, strapIndex);
		chk("coreReset", 8'h1, coreReset);
		@(posedge clock);
		rails[4] <= 1'b1;
		waitDone();
		chk("strapIndex", 8'h5, strapIndex);
	endtask
	task automatic t_timeout();
		@(posedge clock);
		mute <= 1'b1;
		power(5'h1f, 8'h40);
		waitDone();
		cycles(2);
		chk("bootTimeout", 8'h1, bootTimeout);
		chk("strapIndex", 8'h0, strapIndex);
		chk("coreReset", 8'h0, coreReset);
		@(posedge clock);
		mute <= 1'b0;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		t_decode();
		t_hold();
		t_rails();
		t_fall();
		t_dip();
		t_timeout();
		test_done();
	end
endmodule
